/* hdl/codec_serial_control_port.sv */
// Serial control port: three-wire and two-wire register access
`default_nettype none
module codec_serial_control_port
	import cscp_pkg::*;
#(
	parameter logic [DATA_W-1:0] PART_IDENTITY    = 16'h5A5A, // Arbitrary value
	parameter logic [REV_W-1:0]  SILICON_REVISION = 3'h1      // Arbitrary value
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              serialClock,
	input  wire logic              serialDataIn,
	output logic                   serialDataOut,
	output logic                   serialDataOe,
	input  wire logic              strobeIn,
	output logic                   strobeOut,
	output logic                   strobeOe,
	input  wire logic              modeIn,
	output logic                   modeOut,
	output logic                   modeOe,
	output logic                   modePullupEn,
	input  wire logic              jackDetect,
	input  wire logic              tempOk,
	input  wire logic              autoMuteActive,
	input  wire logic              systemClock,
	input  wire logic              pllLock,
	output logic                   twoWireActive,
	output logic      [DATA_W-1:0] powerManagementOne,
	output logic      [DATA_W-1:0] generalPinControl,
	output logic      [DATA_W-1:0] serialPortControl
);

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	logic [3:0] pinLvl;
	logic [3:0] pinRise;
	logic [3:0] pinFall;

	cscp_pin_sync #(
		.WIDTH (4)
	) u_sync (
		.clk     (clk),
		.rst     (rst),
		.pinIn   ({serialClock, serialDataIn, strobeIn, modeIn}),
		.pinSync (pinLvl),
		.pinRise (pinRise),
		.pinFall (pinFall)
	);

	wire sclkLvl   = pinLvl[3];
	wire sclkRise  = pinRise[3];
	wire sclkFall  = pinFall[3];
	wire sdaLvl    = pinLvl[2];
	wire sdaRise   = pinRise[2];
	wire sdaFall   = pinFall[2];
	wire stbRise   = pinRise[1];
	wire stbFall   = pinFall[1];
	wire modeLvl   = pinLvl[0];

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [DATA_W-1:0]  pwr1_q;
	logic [DATA_W-1:0]  gpio_q;
	logic [DATA_W-1:0]  ifc_q;
	logic               twoWire_q;
	logic               override_q;
	logic               pullup_q;
	logic               pinOut_q;
	logic               modeOe_q;
	logic               stbOe_q;
	logic [CNT_W-1:0]   bitCnt_q;
	logic [BYTE_W-1:0]  hdr_q;
	logic [ADDR_W-1:0]  wordAddr_q;
	logic [DATA_W-1:0]  dataSh_q;
	logic [4:0]         dataBits_q;
	logic               wordReady_q;
	logic               reading_q;
	logic [DATA_W-1:0]  rdSh_q;
	logic               sdOe_q;
	cscp_tw_state_type  twState_q;
	logic [3:0]         twCnt_q;
	logic [BYTE_W-2:0]  twSh_q;
	logic [1:0]         twByte_q;
	logic               twAckDone_q;

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	function automatic logic [DATA_W-1:0] readValue(input logic [ADDR_W-1:0] addr,
		input logic [DATA_W-1:0] gpio, input logic [DATA_W-1:0] ifc);
		case (addr)
			REG_IDENT: readValue = PART_IDENTITY;
			REG_PWR1:  readValue = {{(DATA_W-REV_W){1'b0}}, SILICON_REVISION};
			REG_GPIO:  readValue = gpio;
			REG_IFC:   readValue = ifc;
			default:   readValue = '0;
		endcase
	endfunction

	wire       modeIo   = gpio_q[GPIO_MODEIO_BIT];
	wire       address_auto_step  = ifc_q[IFC_ADDRESS_AUTO_STEP_BIT];
	wire [2:0] pinSel   = gpio_q[GPIO_SEL_MSB:GPIO_SEL_LSB];
	wire       pinUsed  = pinSel != SEL_STROBE;

	// ------------------------------------------------------------
	// Three-wire decode
	// ------------------------------------------------------------
	wire [BYTE_W-1:0] hdrNext   = {hdr_q[BYTE_W-2:0], sdaLvl};
	wire              inHdr     = bitCnt_q < CNT_HDR;
	wire              hdrDone   = sclkRise && bitCnt_q == CNT_HDR_LAST;
	wire              rdStart   = !twoWire_q && hdrDone && hdrNext[BYTE_W-1];
	wire              dataBit   = !twoWire_q && sclkRise && !inHdr && !reading_q;
	wire              rollWrite = dataBit && wordReady_q && address_auto_step;
	wire              stbWrite  = !twoWire_q && stbRise && wordReady_q && !reading_q;

	// ------------------------------------------------------------
	// Two-wire decode
	// ------------------------------------------------------------
	wire               startCond = twoWire_q && sdaFall && sclkLvl;
	wire               stopCond  = twoWire_q && sdaRise && sclkLvl;
	wire [BYTE_W-1:0]  twByteIn  = {twSh_q, sdaLvl};
	wire               twByteEnd = sclkRise && twCnt_q == BYTE_LAST;
	wire               twWrite   = twState_q == TW_DATA && twByteEnd && twByte_q == BYTE_LO && !startCond
		&& !stopCond;

	// ------------------------------------------------------------
	// Single write port
	// ------------------------------------------------------------
	wire               wrEn   = twWrite || stbWrite || rollWrite;
	wire [DATA_W-1:0]  wrData = twWrite ? {dataSh_q[DATA_W-1:BYTE_W], twByteIn} : dataSh_q;
	wire               wrRst  = rst || (wrEn && wordAddr_q == REG_IDENT);

	always_ff @(posedge clk) begin
		if (wrRst) begin
			pwr1_q <= PWR1_RST;
			gpio_q <= GPIO_RST;
			ifc_q  <= IFC_RST;
		end else if (wrEn) begin
			case (wordAddr_q)
				REG_PWR1: pwr1_q <= wrData;
				REG_GPIO: gpio_q <= wrData;
				REG_IFC:  ifc_q  <= wrData;
				default:  ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Mode selection and pin functions
	// ------------------------------------------------------------
	logic pinFunc;
	always_comb begin
		case (pinSel)
			SEL_JACK:   pinFunc = jackDetect;
			SEL_TEMP:   pinFunc = tempOk;
			SEL_AMUTE:  pinFunc = autoMuteActive;
			SEL_SYSCLK: pinFunc = systemClock;
			SEL_LOCK:   pinFunc = pllLock;
			default:    pinFunc = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			twoWire_q  <= 1'b0;
			override_q <= 1'b0;
			pullup_q   <= 1'b1;
			pinOut_q   <= 1'b0;
			modeOe_q   <= 1'b0;
			stbOe_q    <= 1'b0;
		end else begin
			twoWire_q  <= !modeIo && !modeLvl;
			override_q <= modeIo;
			pullup_q   <= !override_q;
			pinOut_q   <= pinFunc ^ gpio_q[GPIO_POL_BIT];
			modeOe_q   <= modeIo && pinUsed;
			stbOe_q    <= twoWire_q && pinUsed;
		end
	end

	// ------------------------------------------------------------
	// Serial engines
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst || (twoWire_q && !modeLvl && modeIo)) begin
			bitCnt_q    <= '0;
			hdr_q       <= '0;
			wordAddr_q  <= '0;
			dataSh_q    <= '0;
			dataBits_q  <= '0;
			wordReady_q <= 1'b0;
			reading_q   <= 1'b0;
			rdSh_q      <= '0;
			sdOe_q      <= 1'b0;
			twState_q   <= TW_IDLE;
			twCnt_q     <= '0;
			twSh_q      <= '0;
			twByte_q    <= BYTE_REG;
			twAckDone_q <= 1'b0;
		end else if (!twoWire_q) begin
			twState_q <= TW_IDLE;
			if (stbFall || stbRise) begin
				bitCnt_q    <= '0;
				dataBits_q  <= '0;
				wordReady_q <= 1'b0;
				reading_q   <= 1'b0;
				sdOe_q      <= 1'b0;
				rdSh_q      <= '0;
			end else if (sclkRise) begin
				if (bitCnt_q != CNT_MAX)
					bitCnt_q <= bitCnt_q + 6'h01;
				if (inHdr) begin
					hdr_q      <= hdrNext;
					wordAddr_q <= hdrNext[ADDR_W-1:0];
				end else if (!reading_q) begin
					dataSh_q <= {dataSh_q[DATA_W-2:0], sdaLvl};
					if (rollWrite) begin
						wordAddr_q  <= wordAddr_q + 7'h01;
						dataBits_q  <= 5'h01;
						wordReady_q <= 1'b0;
					end else if (dataBits_q == DATA_BITS - 5'h01) begin
						dataBits_q  <= DATA_BITS;
						wordReady_q <= 1'b1;
					end else if (dataBits_q != DATA_BITS) begin
						dataBits_q <= dataBits_q + 5'h01;
					end
				end
				if (rdStart) begin
					reading_q <= 1'b1;
					sdOe_q    <= 1'b1;
					rdSh_q    <= readValue(hdrNext[ADDR_W-1:0], gpio_q, ifc_q);
				end
			end else if (sclkFall && reading_q && bitCnt_q > CNT_HDR) begin
				if (bitCnt_q >= CNT_WORD) begin
					sdOe_q <= 1'b0;
					rdSh_q <= '0;
				end else begin
					rdSh_q <= {rdSh_q[DATA_W-2:0], 1'b0};
				end
			end
		end else begin
			reading_q <= 1'b0;
			rdSh_q    <= '0;
			if (startCond) begin
				twState_q <= TW_ADDR;
				twCnt_q   <= '0;
				sdOe_q    <= 1'b0;
			end else if (stopCond) begin
				twState_q <= TW_IDLE;
				sdOe_q    <= 1'b0;
			end else begin
				case (twState_q)
					TW_ADDR: begin
						if (sclkRise) begin
							twSh_q  <= twByteIn[BYTE_W-2:0];
							twCnt_q <= twCnt_q + 4'h1;
						end
						if (twByteEnd) begin
							if (twSh_q == BUS_ADDR && !sdaLvl) begin
								twState_q   <= TW_ACK;
								twByte_q    <= BYTE_REG;
								twAckDone_q <= 1'b0;
							end else begin
								twState_q <= TW_IDLE;
							end
						end
					end
					TW_ACK: begin
						if (sclkFall) begin
							if (!twAckDone_q) begin
								sdOe_q      <= 1'b1;
								twAckDone_q <= 1'b1;
							end else begin
								sdOe_q    <= 1'b0;
								twState_q <= TW_DATA;
								twCnt_q   <= '0;
							end
						end
					end
					TW_DATA: begin
						if (sclkRise) begin
							twSh_q  <= twByteIn[BYTE_W-2:0];
							twCnt_q <= twCnt_q + 4'h1;
						end
						if (twByteEnd) begin
							twState_q   <= TW_ACK;
							twAckDone_q <= 1'b0;
							case (twByte_q)
								BYTE_REG: begin
									wordAddr_q <= twByteIn[ADDR_W-1:0];
									twByte_q   <= BYTE_HI;
								end
								BYTE_HI: begin
									dataSh_q[DATA_W-1:BYTE_W] <= twByteIn;
									twByte_q                  <= BYTE_LO;
								end
								default: begin
									if (address_auto_step) begin
										wordAddr_q <= wordAddr_q + 7'h01;
										twByte_q   <= BYTE_HI;
									end
								end
							endcase
						end
					end
					default: twState_q <= TW_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign serialDataOut      = rdSh_q[DATA_W-1];
	assign serialDataOe       = sdOe_q;
	assign strobeOut          = pinOut_q;
	assign strobeOe           = stbOe_q;
	assign modeOut            = pinOut_q;
	assign modeOe             = modeOe_q;
	assign modePullupEn       = pullup_q;
	assign twoWireActive      = twoWire_q;
	assign powerManagementOne = pwr1_q;
	assign generalPinControl  = gpio_q;
	assign serialPortControl  = ifc_q;

endmodule
`default_nettype wire

/* hdl/cscp_pin_sync.sv */
// Two-stage pin synchroniser with edge detection
`default_nettype none
module cscp_pin_sync
	import cscp_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync,
	output logic      [WIDTH-1:0] pinRise,
	output logic      [WIDTH-1:0] pinFall
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] last_q;

	// ------------------------------------------------------------
	// Resynchronisation; first stage feeds only the second
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '1;
			sync_q <= '1;
			last_q <= '1;
		end else begin
			meta_q <= pinIn;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign pinSync = sync_q;
	assign pinRise = sync_q & ~last_q;
	assign pinFall = ~sync_q & last_q;

endmodule
`default_nettype wire

/* inc/cscp_pkg.sv */
// Constants and types shared by the codec serial control port
`default_nettype none
package cscp_pkg;

	// ------------------------------------------------------------
	// Word layout
	// ------------------------------------------------------------
	localparam int           ADDR_W      = 7;
	localparam int           DATA_W      = 16;
	localparam int           BYTE_W      = 8;
	localparam int           REV_W       = 3;
	localparam int           CNT_W       = 6;
	localparam logic [CNT_W-1:0] CNT_HDR_LAST  = 6'h07;
	localparam logic [CNT_W-1:0] CNT_HDR       = 6'h08;
	localparam logic [CNT_W-1:0] CNT_WORD      = 6'h18;
	localparam logic [CNT_W-1:0] CNT_MAX       = 6'h3F;
	localparam logic [4:0]   DATA_BITS   = 5'h10;
	localparam logic [3:0]   BYTE_LAST   = 4'h7;

	// ------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_IDENT = 7'h00;
	localparam logic [ADDR_W-1:0] REG_PWR1  = 7'h01;
	localparam logic [ADDR_W-1:0] REG_GPIO  = 7'h08;
	localparam logic [ADDR_W-1:0] REG_IFC   = 7'h09;
	localparam logic [DATA_W-1:0] PWR1_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] GPIO_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] IFC_RST   = 16'h0002;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int GPIO_MODEIO_BIT = 7;
	localparam int GPIO_POL_BIT    = 3;
	localparam int GPIO_SEL_MSB    = 2;
	localparam int GPIO_SEL_LSB    = 0;
	localparam int IFC_ADDRESS_AUTO_STEP_BIT = 1;

	// ------------------------------------------------------------
	// Pin function codes
	// ------------------------------------------------------------
	localparam logic [2:0] SEL_STROBE = 3'h0;
	localparam logic [2:0] SEL_JACK   = 3'h1;
	localparam logic [2:0] SEL_TEMP   = 3'h2;
	localparam logic [2:0] SEL_AMUTE  = 3'h3;
	localparam logic [2:0] SEL_SYSCLK = 3'h4;
	localparam logic [2:0] SEL_LOCK   = 3'h5;

	// ------------------------------------------------------------
	// Two-wire bus
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] BUS_ADDR = 7'h1A;
	localparam logic [1:0]   BYTE_REG  = 2'h0;
	localparam logic [1:0]   BYTE_HI   = 2'h1;
	localparam logic [1:0]   BYTE_LO   = 2'h2;

	typedef enum logic [2:0] {
		TW_IDLE,
		TW_ADDR,
		TW_ACK,
		TW_DATA
	} cscp_tw_state_type;

endpackage
`default_nettype wire

/* tb/codec_serial_control_port_bench.sv */
// Self-checking bench of the serial control port
`default_nettype none
module codec_serial_control_port_bench
	import cscp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Pins and wire levels
	// ----
	localparam logic [15:0] IDV = 16'h3C96; // Arbitrary value
	localparam logic [2:0]  REV = 3'h5;     // Arbitrary value
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hostEn = 1'b0;
	logic        modeHost = 1'b1;
	logic        tog = 1'b0;
	logic [4:0]  st = 5'h00;
	logic [15:0] d;
	logic [15:0] g;
	logic [15:0] s;
	int          fails = 0;
	int          n_checks = 0;
	int          cyc = 0;
	wire logic   sclk, hsdo, hcsb, dOut, dOe, sOut, sOe, mOut, mOe, pullEn, twoW;
	wire logic [15:0] pm1, gpc, spc;
	wire logic   sdaW = dOe ? dOut : hsdo;
	wire logic   csbW = sOe ? sOut : hcsb;
	// Undriven mode pin without pull-up toggles
	wire logic   modeW = mOe ? mOut : hostEn ? modeHost : (pullEn | tog);
	codec_serial_control_port #(.PART_IDENTITY(IDV), .SILICON_REVISION(REV)) dut (
		.clk(clk), .rst(rst), .serialClock(sclk), .serialDataIn(sdaW),
		.serialDataOut(dOut), .serialDataOe(dOe), .strobeIn(csbW), .strobeOut(sOut),
		.strobeOe(sOe), .modeIn(modeW), .modeOut(mOut), .modeOe(mOe), .modePullupEn(pullEn),
		.jackDetect(st[0]), .tempOk(st[1]), .autoMuteActive(st[2]), .systemClock(st[3]),
		.pllLock(st[4]), .twoWireActive(twoW), .powerManagementOne(pm1),
		.generalPinControl(gpc), .serialPortControl(spc)
	);
	cscp_host_model host (.clk(clk), .sdaW(sdaW), .sclk(sclk), .sdo(hsdo), .word_latch_strobe(hcsb));
	// ----
	// Helpers
	// ----
	`define CHK(gv, ev) chk(gv, ev);
	task chk(input logic [15:0] gv, input logic [15:0] ev);
		n_checks++;
		if (gv !== ev) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, gv, ev);
		end
	endtask
	task done(input string t);
		$display("Test %s finished", t);
	endtask
	task print_verdict();
		$display("Checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function logic pinv(input logic [2:0] c, input logic [4:0] v);
		return (c >= 3'h1 && c <= 3'h5) ? v[c - 3'h1] : 1'b0;
	endfunction
	task w3(input logic [7:0] a, input logic [15:0] v, input int n = 24);
		host.w3({a, v, 16'h0000}, n);
	endtask
	task tw(input logic [7:0] q[$]);
		host.nAck = 0;
		host.st2();
		foreach (q[i])
			host.b2(q[i]);
		host.sp2();
	endtask
	always #4 clk = ~clk;
	always @(posedge clk) begin
		tog <= ~tog;
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			fails++;
			print_verdict();
		end
	end
	// ----
	// Tests
	// ----
	initial begin
		void'($urandom(32'h97773DF9));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		`CHK(spc, IFC_RST)
		`CHK({14'h0, pullEn, twoW}, 16'h0002)
		done("reset");
		d = 16'($urandom);
		w3(8'h01, d);
		`CHK(pm1, d)
		w3(8'h01, ~d, 20);
		`CHK(pm1, d)
		g = 16'($urandom) & 16'hFF78;
		s = 16'($urandom) | 16'h0002;
		host.w3({8'h08, g, s}, 40);
		`CHK(gpc, g)
		`CHK(spc, s)
		w3(8'h09, 16'h0000);
		host.w3({8'h01, d, s}, 40);
		`CHK(pm1, s)
		w3(8'h80, 16'($urandom));
		`CHK(host.rd, IDV)
		w3(8'h81, 16'($urandom));
		`CHK(host.rd, {13'h0, REV})
		w3(8'h88, 16'($urandom));
		`CHK(host.rd, g)
		w3(8'h00, 16'($urandom));
		`CHK(pm1, PWR1_RST)
		`CHK(gpc, GPIO_RST)
		`CHK(spc, IFC_RST)
		done("three-wire");
		// First pass with mode driver off and mode held low, later passes with the device driving mode
		for (int c = 0; c < 8; c++) begin
			st <= 5'($urandom);
			g = 16'($urandom) & 16'h0008 | 16'h0080 | 16'(c);
			w3(8'h08, g);
			hostEn <= 1'b1;
			modeHost <= 1'b0;
			repeat (8) @(posedge clk);
			`CHK({13'h0, mOe, pullEn, twoW}, {13'h0, c != 0, 2'b00})
			if (c != 0)
				`CHK({15'h0, mOut}, {15'h0, pinv(3'(c), st) ^ g[3]})
		end
		modeHost <= 1'b1;
		w3(8'h00, 16'h0000);
		modeHost <= 1'b0;
		repeat (10) @(posedge clk);
		`CHK({15'h0, twoW}, 16'h0001)
		done("mode pin");
		d = 16'($urandom);
		tw('{8'h34, 8'h01, d[15:8], d[7:0]});
		`CHK(16'(host.nAck), 16'h0004)
		`CHK(pm1, d)
		// Mode-as-io bit stays clear in two-wire
		g = 16'($urandom) & 16'hFF78 | 16'h0005;
		s = 16'($urandom) | 16'h0002;
		tw('{8'h34, 8'h08, g[15:8], g[7:0], s[15:8], s[7:0]});
		`CHK(gpc, g)
		`CHK(spc, s)
		`CHK({14'h0, sOe, sOut}, {14'h0, 1'b1, st[4] ^ g[3]})
		for (int i = 0; i < 2; i++) begin
			tw('{i ? 8'h35 : 8'h36, 8'h01, ~d[15:8], ~d[7:0]});
			`CHK(16'(host.nAck), 16'h0000)
		end
		`CHK(pm1, d)
		host.st2();
		host.b2(8'h34);
		host.b2(8'h01);
		host.b2(~d[15:8]);
		host.st2();
		host.nAck = 0;
		host.b2(8'h77);
		host.sp2();
		`CHK(16'(host.nAck), 16'h0000)
		`CHK(pm1, d)
		done("two-wire");
		print_verdict();
	end
endmodule
`default_nettype wire

/* tb/cscp_host_model.sv */
// Behavioural host of the serial control pins
`default_nettype none
module cscp_host_model (
	input  wire logic clk,
	input  wire logic sdaW,
	output var  logic sclk,
	output var  logic sdo,
	output var  logic word_latch_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rd = 16'h0000;
	logic        smp = 1'b1;
	int          nAck = 0;
	initial begin
		sclk = 1'b0;
		sdo = 1'b1;
		word_latch_strobe = 1'b1;
	end
	// ----
	// Serial clock of 64 ns, line sampled late in high phase
	// ----
	task w(input int n);
		repeat (n) @(posedge clk);
	endtask
	task bit1(input logic b);
		sclk <= 1'b0;
		w(2);
		sdo <= b;
		w(2);
		sclk <= 1'b1;
		w(4);
		smp = sdaW;
	endtask
	task w3(input logic [39:0] v, input int n);
		word_latch_strobe <= 1'b0;
		w(4);
		for (int i = 0; i < n; i++) begin
			bit1(v[39 - i]);
			if (i >= 8)
				rd = {rd[14:0], smp};
		end
		sclk <= 1'b0;
		w(4);
		word_latch_strobe <= 1'b1;
		w(8);
	endtask
	task st2();
		bit1(1'b1);
		sdo <= 1'b0;
		w(4);
	endtask
	task sp2();
		bit1(1'b0);
		sdo <= 1'b1;
		w(4);
	endtask
	task b2(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			bit1(b[i]);
		bit1(1'b1);
		if (smp === 1'b0)
			nAck++;
	endtask
endmodule
`default_nettype wire

/* tb/cscp_properties.sv */
// Checker of the serial control port pins
`default_nettype none
module cscp_properties
	import cscp_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              modeIn,
	input wire logic              serialDataOut,
	input wire logic              serialDataOe,
	input wire logic              modeOe,
	input wire logic              modePullupEn,
	input wire logic              twoWireActive,
	input wire logic [DATA_W-1:0] generalPinControl,
	input wire logic [DATA_W-1:0] serialPortControl
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Pin and register relations
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire logic       io = generalPinControl[GPIO_MODEIO_BIT];
	wire logic [2:0] sel = generalPinControl[2:0];
	property p_rst_val;
		$fell(rst) |-> serialPortControl == IFC_RST && generalPinControl == GPIO_RST && modePullupEn;
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("Reset value wrong");
	property p_two_sel; (!modeIn && !io) [*6] |-> twoWireActive; endproperty
	a_two_sel: assert property (p_two_sel) else $error("Two-wire not selected");
	property p_three_sel; (modeIn || io) [*6] |-> !twoWireActive; endproperty
	a_three_sel: assert property (p_three_sel) else $error("Three-wire not selected");
	property p_pull_after; $fell(modePullupEn) |-> $past(io) && $past(io, 2); endproperty
	a_pull_after: assert property (p_pull_after) else $error("Pull-up off before override");
	property p_pull_off; io [*4] |-> !modePullupEn; endproperty
	a_pull_off: assert property (p_pull_off) else $error("Pull-up still on");
	property p_mode_drv; $rose(modeOe) |-> io && sel != SEL_STROBE; endproperty
	a_mode_drv: assert property (p_mode_drv) else $error("Mode driver enabled wrongly");
	property p_ack_low; serialDataOe && twoWireActive |-> !serialDataOut; endproperty
	a_ack_low: assert property (p_ack_low) else $error("Ack not low");
	property p_ack_len;
		$rose(serialDataOe) && twoWireActive |-> serialDataOe [*7] ##[1:3] !serialDataOe;
	endproperty
	a_ack_len: assert property (p_ack_len) else $error("Ack length wrong");
	property p_read_len; $rose(serialDataOe) && !twoWireActive |-> serialDataOe [*8]; endproperty
	a_read_len: assert property (p_read_len) else $error("Read drive too short");
endmodule
bind codec_serial_control_port cscp_properties u_props (.clk, .rst, .modeIn, .serialDataOut,
	.serialDataOe, .modeOe, .modePullupEn, .twoWireActive, .generalPinControl, .serialPortControl);
`default_nettype wire
